// ### common/dpswa_cfg.svh
// constants for the dual path slave write arbiter
`ifndef DPSWA_CFG_SVH
`define DPSWA_CFG_SVH
`define DPSWA_ADDR_W 32
`define DPSWA_DATA_W 32
`define DPSWA_ID_W 4
`define DPSWA_PATH_A 1'h0
`define DPSWA_PATH_B 1'h1
`define DPSWA_FLAG_CLR 1'h0
`define DPSWA_FLAG_SET 1'h1
`define DPSWA_ZERO_ADDR 32'h0000_0000
`define DPSWA_ZERO_DATA 32'h0000_0000
`define DPSWA_ZERO_ID 4'h0
`endif

// ### common/dpswa_pkg.sv
// types for the dual path slave write arbiter
`default_nettype none
package dpswa_pkg;
   typedef enum logic [1:0] {
      DPSWA_IDLE,
      DPSWA_DATA,
      DPSWA_RESP
   } dpswa_state_t;
endpackage : dpswa_pkg
`default_nettype wire

// ### design/dpswa_cmd_hold.sv
// one path's command holding stage
`timescale 1ns/1ps
`default_nettype none
`include "dpswa_cfg.svh"
module dpswa_cmd_hold (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic [`DPSWA_ADDR_W-1:0] cmd_addr_i,
   input wire logic [`DPSWA_ID_W-1:0] cmd_id_i,
   input wire logic take_i,
   output logic pend_o,
   output logic [`DPSWA_ADDR_W-1:0] addr_o,
   output logic [`DPSWA_ID_W-1:0] id_o
);
   logic pend_q;
   logic [`DPSWA_ADDR_W-1:0] addr_q;
   logic [`DPSWA_ID_W-1:0] id_q;

   // command stays held while the slave stalls
   assign cmd_ready_o = !pend_q;
   assign pend_o = pend_q;
   assign addr_o = addr_q;
   assign id_o = id_q;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_q <= `DPSWA_FLAG_CLR;
      end else if (cmd_valid_i && !pend_q) begin
         pend_q <= `DPSWA_FLAG_SET;
      end else if (take_i) begin
         pend_q <= `DPSWA_FLAG_CLR;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_q <= `DPSWA_ZERO_ADDR;
         id_q <= `DPSWA_ZERO_ID;
      end else if (cmd_valid_i && !pend_q) begin
         addr_q <= cmd_addr_i;
         id_q <= cmd_id_i;
      end
   end
endmodule : dpswa_cmd_hold
`default_nettype wire

// ### design/dpswa_arbiter.sv
// two-path write arbiter in front of a core slave_dma_port
`timescale 1ns/1ps
`default_nettype none
`include "dpswa_cfg.svh"
// How it works
// - two input paths, each own master set
// - path fixed by issuing master port only
// - slave busy stalls commands on both paths
// - both pending: either path may win
// - data expected in command selection order
// - no new selection until data finishes
module dpswa_arbiter (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // path_a_master side
   input wire logic a_cmd_valid_i,
   output logic a_cmd_ready_o,
   input wire logic [`DPSWA_ADDR_W-1:0] a_cmd_addr_i,
   input wire logic [`DPSWA_ID_W-1:0] a_cmd_id_i,
   input wire logic a_wdata_valid_i,
   output logic a_wdata_ready_o,
   input wire logic [`DPSWA_DATA_W-1:0] a_wdata_i,
   input wire logic a_wlast_i,
   output logic a_sel_o,
   output logic a_done_o,
   output logic [`DPSWA_ID_W-1:0] a_done_id_o,
   // path_b_master side
   input wire logic b_cmd_valid_i,
   output logic b_cmd_ready_o,
   input wire logic [`DPSWA_ADDR_W-1:0] b_cmd_addr_i,
   input wire logic [`DPSWA_ID_W-1:0] b_cmd_id_i,
   input wire logic b_wdata_valid_i,
   output logic b_wdata_ready_o,
   input wire logic [`DPSWA_DATA_W-1:0] b_wdata_i,
   input wire logic b_wlast_i,
   output logic b_sel_o,
   output logic b_done_o,
   output logic [`DPSWA_ID_W-1:0] b_done_id_o,
   // slave_dma_port side
   output logic s_cmd_valid_o,
   input wire logic s_cmd_ready_i,
   output logic [`DPSWA_ADDR_W-1:0] s_cmd_addr_o,
   output logic s_wdata_valid_o,
   input wire logic s_wdata_ready_i,
   output logic [`DPSWA_DATA_W-1:0] s_wdata_o,
   output logic s_wlast_o
);
   dpswa_pkg::dpswa_state_t state_q;
   logic pend_a;
   logic pend_b;
   logic [`DPSWA_ADDR_W-1:0] addr_a;
   logic [`DPSWA_ADDR_W-1:0] addr_b;
   logic [`DPSWA_ID_W-1:0] id_a;
   logic [`DPSWA_ID_W-1:0] id_b;
   logic pick;
   logic grant_q;
   logic last_q;
   logic take_a;
   logic take_b;
   logic cmd_fire;
   logic data_fire;
   logic done_q;
   logic [`DPSWA_ID_W-1:0] done_id_q;
   logic [`DPSWA_ID_W-1:0] sel_id_q;
   logic dvalid;
   logic dlast;
   logic prev_sel_q;

   // each path is its own port pair; the address never steers
   dpswa_cmd_hold u_hold_a (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .cmd_valid_i(a_cmd_valid_i),
      .cmd_ready_o(a_cmd_ready_o),
      .cmd_addr_i(a_cmd_addr_i),
      .cmd_id_i(a_cmd_id_i),
      .take_i(take_a),
      .pend_o(pend_a),
      .addr_o(addr_a),
      .id_o(id_a)
   );

   dpswa_cmd_hold u_hold_b (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .cmd_valid_i(b_cmd_valid_i),
      .cmd_ready_o(b_cmd_ready_o),
      .cmd_addr_i(b_cmd_addr_i),
      .cmd_id_i(b_cmd_id_i),
      .take_i(take_b),
      .pend_o(pend_b),
      .addr_o(addr_b),
      .id_o(id_b)
   );

   // round robin on a tie; order across masters is not promised
   always_comb begin
      if (pend_a && pend_b) begin
         pick = !last_q;
      end else begin
         pick = pend_b ? `DPSWA_PATH_B : `DPSWA_PATH_A;
      end
   end

   // offer only in idle, so a busy slave leaves both held
   assign s_cmd_valid_o = (state_q == dpswa_pkg::DPSWA_IDLE) && (pend_a || pend_b);
   assign s_cmd_addr_o = (pick == `DPSWA_PATH_B) ? addr_b : addr_a;
   assign cmd_fire = s_cmd_valid_o && s_cmd_ready_i;
   assign take_a = cmd_fire && (pick == `DPSWA_PATH_A);
   assign take_b = cmd_fire && (pick == `DPSWA_PATH_B);

   // data only from the path whose command was selected last
   assign dvalid = (grant_q == `DPSWA_PATH_B) ? b_wdata_valid_i : a_wdata_valid_i;
   assign dlast = (grant_q == `DPSWA_PATH_B) ? b_wlast_i : a_wlast_i;
   assign s_wdata_valid_o = (state_q == dpswa_pkg::DPSWA_DATA) && dvalid;
   assign s_wdata_o = (grant_q == `DPSWA_PATH_B) ? b_wdata_i : a_wdata_i;
   assign s_wlast_o = s_wdata_valid_o && dlast;
   assign a_wdata_ready_o = (state_q == dpswa_pkg::DPSWA_DATA) &&
      (grant_q == `DPSWA_PATH_A) && s_wdata_ready_i;
   assign b_wdata_ready_o = (state_q == dpswa_pkg::DPSWA_DATA) &&
      (grant_q == `DPSWA_PATH_B) && s_wdata_ready_i;
   assign data_fire = s_wdata_valid_o && s_wdata_ready_i;
   assign a_sel_o = take_a;
   assign b_sel_o = take_b;

   // one write in flight; this is where the crossed-order hazard comes from
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= dpswa_pkg::DPSWA_IDLE;
      end else begin
         case (state_q)
            dpswa_pkg::DPSWA_IDLE: begin
               if (cmd_fire) begin
                  state_q <= dpswa_pkg::DPSWA_DATA;
               end
            end
            dpswa_pkg::DPSWA_DATA: begin
               if (data_fire && dlast) begin
                  state_q <= dpswa_pkg::DPSWA_RESP;
               end
            end
            dpswa_pkg::DPSWA_RESP: begin
               state_q <= dpswa_pkg::DPSWA_IDLE;
            end
            default: begin
               state_q <= dpswa_pkg::DPSWA_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         grant_q <= `DPSWA_PATH_A;
         last_q <= `DPSWA_PATH_B;
         sel_id_q <= `DPSWA_ZERO_ID;
      end else if (cmd_fire) begin
         grant_q <= pick;
         last_q <= pick;
         sel_id_q <= (pick == `DPSWA_PATH_B) ? id_b : id_a;
      end
   end

   // completion after the last beat is taken by the slave
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_q <= `DPSWA_FLAG_CLR;
         done_id_q <= `DPSWA_ZERO_ID;
      end else begin
         done_q <= (state_q == dpswa_pkg::DPSWA_DATA) && data_fire && dlast;
         done_id_q <= sel_id_q;
      end
   end

   assign a_done_o = done_q && (grant_q == `DPSWA_PATH_A);
   assign b_done_o = done_q && (grant_q == `DPSWA_PATH_B);
   assign a_done_id_o = done_id_q;
   assign b_done_id_o = done_id_q;

   // checker-side record of the last path taken, seen only through the select pulses
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_sel_q <= `DPSWA_PATH_B;
      end else if (a_sel_o || b_sel_o) begin
         prev_sel_q <= b_sel_o;
      end
   end

   sequence last_beat_s;
      data_fire && dlast;
   endsequence

   no_reissue_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      last_beat_s |=> !s_cmd_valid_o ##1 1'h1)
      else $error("command offered during completion cycle");
   stall_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (pend_a && !take_a) |=> pend_a)
      else $error("path a command lost while stalled");
   data_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_q == dpswa_pkg::DPSWA_DATA) |-> !s_cmd_valid_o)
      else $error("selection while data outstanding");
   data_path_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_wdata_valid_o |-> ((grant_q == `DPSWA_PATH_B) ?
         (b_wdata_valid_i && !a_wdata_ready_o) : (a_wdata_valid_i && !b_wdata_ready_o)))
      else $error("data from wrong path");
   done_time_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      last_beat_s |=> (a_done_o || b_done_o))
      else $error("completion not one cycle after last beat");
   done_cause_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (a_done_o || b_done_o) |-> $past(data_fire) && $past(dlast))
      else $error("completion without last beat");
   grant_rec_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      take_b |=> (grant_q == `DPSWA_PATH_B) && !a_wdata_ready_o)
      else $error("path b grant not recorded");
   fair_tie_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (cmd_fire && pend_a && pend_b) |-> (b_sel_o != prev_sel_q) && (a_sel_o != b_sel_o))
      else $error("tie not alternated");
   sel_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !(a_sel_o && b_sel_o))
      else $error("both paths selected");
endmodule : dpswa_arbiter
`default_nettype wire

// ### tb/dpswa_slave_model.sv
// core memory slave port model, stalls when busy, slow data mode
`timescale 1ns/1ps
`default_nettype none
module dpswa_slave_model (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic busy_i,
   input wire logic slow_i,
   output logic s_cmd_ready_o,
   output logic s_wdata_ready_o
);
   logic tog_q;
   // slow mode takes a data beat only every other cycle
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) tog_q <= 1'h0;
      else tog_q <= !tog_q;
   end
   assign s_cmd_ready_o = !busy_i;
   assign s_wdata_ready_o = !busy_i && (!slow_i || tog_q);
endmodule : dpswa_slave_model
`default_nettype wire

// ### tb/dpswa_arbiter_test.sv
// self-checking bench for the two-path write arbiter
`timescale 1ns/1ps
`default_nettype none
`include "dpswa_cfg.svh"
module dpswa_arbiter_test;
   logic sys_clk_i = 1'h0;
   logic rst_n_i = 1'h0;
   logic busy = 1'h0;
   logic slow = 1'h0;
   logic cv[2] = '{1'h0, 1'h0};
   logic wv[2] = '{1'h0, 1'h0};
   logic wl[2] = '{1'h0, 1'h0};
   logic [31:0] ca[2] = '{32'h0000_1000, 32'h0000_2000};
   logic [31:0] wd[2] = '{32'h0, 32'h0};
   logic [3:0] ci[2] = '{4'h3, 4'hC};
   logic cr[2], wr[2], sel[2], dn[2];
   logic [3:0] di[2];
   logic scv, scr, swv, swr, swl;
   logic [31:0] sca, swd;
   int errors = 0;
   int samples_checked = 0;
   dpswa_arbiter uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .a_cmd_valid_i(cv[0]), .a_cmd_ready_o(cr[0]), .a_cmd_addr_i(ca[0]),
      .a_cmd_id_i(ci[0]), .a_wdata_valid_i(wv[0]), .a_wdata_ready_o(wr[0]),
      .a_wdata_i(wd[0]), .a_wlast_i(wl[0]), .a_sel_o(sel[0]), .a_done_o(dn[0]),
      .a_done_id_o(di[0]), .b_cmd_valid_i(cv[1]), .b_cmd_ready_o(cr[1]),
      .b_cmd_addr_i(ca[1]), .b_cmd_id_i(ci[1]), .b_wdata_valid_i(wv[1]),
      .b_wdata_ready_o(wr[1]), .b_wdata_i(wd[1]), .b_wlast_i(wl[1]),
      .b_sel_o(sel[1]), .b_done_o(dn[1]), .b_done_id_o(di[1]),
      .s_cmd_valid_o(scv), .s_cmd_ready_i(scr), .s_cmd_addr_o(sca),
      .s_wdata_valid_o(swv), .s_wdata_ready_i(swr), .s_wdata_o(swd),
      .s_wlast_o(swl));
   dpswa_slave_model slv (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .busy_i(busy), .slow_i(slow), .s_cmd_ready_o(scr), .s_wdata_ready_o(swr));
   initial begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize
   // one command per master outstanding at a time keeps the hazard away
   task automatic offer(input logic a, input logic b);
      @(posedge sys_clk_i);
      cv[0] <= a;
      cv[1] <= b;
      @(negedge sys_clk_i);
      chk({cr[0], cr[1]}, 2'h3);
      @(posedge sys_clk_i);
      cv[0] <= 1'h0;
      cv[1] <= 1'h0;
   endtask : offer
   // sel is a one-cycle pulse, so look from just after the edge
   task automatic wait_sel(input int p);
      int n;
      n = 0;
      #1;
      while (sel[p] !== 1'h1 && n < 50) begin
         @(negedge sys_clk_i);
         n++;
      end
      chk({sel[p], sel[1-p]}, 2'h2);
   endtask : wait_sel
   task automatic send(input int p, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      wv[p] <= 1'h1;
      wl[p] <= 1'h1;
      wd[p] <= d;
      do begin
         @(negedge sys_clk_i);
         chk({sel[1-p], dn[p], wr[1-p]}, 3'h0);
         n++;
      end while (wr[p] !== 1'h1 && n < 50);
      chk({swv, swl}, 2'h3);
      chk(swd, d);
      @(posedge sys_clk_i);
      wv[p] <= 1'h0;
      wl[p] <= 1'h0;
      wd[p] <= ~d;
      @(negedge sys_clk_i);
      chk({dn[p], di[p]}, {1'h1, ci[p]});
      @(negedge sys_clk_i);
      chk(dn[p], 1'h0);
   endtask : send
   task automatic single_write(input int p);
      offer(p == 0, p == 1);
      wait_sel(p);
      chk(sca, ca[p]);
      send(p, 32'hA5A5_0001 + p);
   endtask : single_write
   // busy slave holds both; ties alternate against the last path selected
   task automatic tie(input int w);
      @(posedge sys_clk_i);
      busy <= 1'h1;
      slow <= (w == 1);
      offer(1'h1, 1'h1);
      repeat (4) begin
         @(negedge sys_clk_i);
         chk({cr[0], cr[1], sel[0], sel[1], scv}, 5'h01);
      end
      @(posedge sys_clk_i);
      busy <= 1'h0;
      wait_sel(w);
      chk(sca, ca[w]);
      send(w, 32'h5A5A_0000 + w);
      wait_sel(1 - w);
      chk(sca, ca[1-w]);
      send(1 - w, 32'h0F0F_0000 + w);
   endtask : tie
   initial begin
      @(negedge sys_clk_i);
      chk({cr[0], cr[1], wr[0], wr[1], scv, swv, dn[0], dn[1]}, 8'hC0);
      repeat (10) @(posedge sys_clk_i);
      rst_n_i <= 1'h1;
      single_write(0);
      tie(1);
      single_write(1);
      tie(0);
      summarize();
   end
   initial begin
      repeat (3000) @(posedge sys_clk_i);
      errors++;
      summarize();
   end
endmodule : dpswa_arbiter_test
`default_nettype wire
